/* File: bench/gffm_gate_cards.sv */
// Gate driver cards: feedback toggles on each delivered pulse on a good link (mode 0)
`timescale 1ns/1ns
`default_nettype none
module gffm_gate_cards
	import gffm_pkg::*;
(
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    rst_n,
	// Links: 0 good, 1 feedback lost, 2 gating lost, 3 noisy
	input wire logic [NUM_DEV-1:0]      gateOut,
	input wire logic [NUM_DEV-1:0][1:0] mode,
	output var logic [NUM_DEV-1:0]      feedback
);
	logic [NUM_DEV-1:0] state;
	logic [NUM_DEV-1:0] prevGate;
	logic [6:0]         ticks;

	// Noisy link flips every 64 cycles, so three polls 50 cycles apart never all agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
			prevGate <= '0;
			ticks <= '0;
		end else begin
			prevGate <= gateOut;
			state <= state ^ (gateOut & ~prevGate);
			ticks <= ticks + 7'h01;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_DEV; i++)
			feedback[i] = mode[i] == 2'h0 ? state[i] : mode[i] == 2'h1 ? 1'b0 :
				mode[i] == 2'h2 ? 1'b1 : ticks[6];
	end
endmodule : gffm_gate_cards
`default_nettype wire

/* File: bench/gffm_monitor_properties.sv */
// Port checks for the gate feedback fault monitor
`timescale 1ns/1ns
`default_nettype none
module gffm_monitor_properties
	import gffm_pkg::*;
(
	// Clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// Watched ports
	input wire logic [NUM_DEV-1:0] gateOut,
	input wire logic               driveReset,
	input wire logic               busy,
	input wire logic               diagDone,
	input wire gffm_fault_t        faults,
	input wire gffm_report_t       report
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [TMR_W-1:0] gateCnt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			gateCnt <= '0;
		else
			gateCnt <= (gateOut != '0) ? gateCnt + 1'b1 : '0;
	end

	// An aborted pulse is legally short
	pulse_len_a: assert property (gateOut == '0 && $past(gateOut) != '0 && !$past(driveReset)
		|-> gateCnt == GATE_PULSE_CYC) else $error("gate pulse length wrong");
	gate_busy_a: assert property (gateOut != '0 |-> busy)
		else $error("gate pulse outside a sequence");
	reset_diag_a: assert property (driveReset |-> ##[1:4] busy)
		else $error("no pass after drive reset");
	fault_sticky_a: assert property ((($past(faults) & ~faults) != '0) |-> $past(driveReset))
		else $error("fault dropped without reset");
	fault_eval_a: assert property (((faults & ~$past(faults)) != '0) |-> $fell(busy))
		else $error("fault set outside evaluation");
	done_eval_a: assert property (diagDone |-> $fell(busy))
		else $error("pass end misplaced");
	code_map_a: assert property (report.valid |-> report.code ==
		(report.kind == KIND_FBK ? FBK_CODES[report.pos] :
		report.kind == KIND_GAT ? GAT_CODES[report.pos] : ONL_CODES[report.pos]))
		else $error("fault code wrong");
	report_gap_a: assert property (report.valid |=> !report.valid [*2])
		else $error("reports too close");

	cover property (diagDone);
	cover property (report.valid && report.kind == KIND_ONL);
	cover property (report.valid && report.kind == KIND_GAT);
endmodule : gffm_monitor_properties

bind gffm_monitor gffm_monitor_properties props (.clk(clk), .rst_n(rst_n), .gateOut(gateOut),
	.driveReset(driveReset), .busy(busy), .diagDone(diagDone), .faults(faults), .report(report));
`default_nettype wire

/* File: bench/gffm_monitor_tb.sv */
// Self-checking bench for the gate feedback fault monitor
`timescale 1ns/1ns
`default_nettype none
module gffm_monitor_tb
	import gffm_pkg::*;
;
	logic clk, rst_n, running, gateCmd, diagReq, driveReset, busy, diagDone;
	logic [NUM_DEV-1:0]      feedback, gateOut, gateMask, fb, gt;
	logic [NUM_DEV-1:0][1:0] mode;
	logic [CNT_W-1:0]        delay;
	gffm_cause_t             diagCause, activeCause;
	gffm_cause_t             causes [3] = '{CAUSE_CONTACTOR, CAUSE_START, CAUSE_STOP};
	gffm_fault_t             faults;
	gffm_report_t            report, firstRep;
	int                      failCount = 0, totalChecks = 0;

	gffm_monitor dut (.clk(clk), .rst_n(rst_n), .feedback(feedback), .gateOut(gateOut),
		.running(running), .gateCmd(gateCmd), .gateMask(gateMask), .diagReq(diagReq),
		.diagCause(diagCause), .driveReset(driveReset), .diagnosticDelaySetting(delay),
		.busy(busy), .diagDone(diagDone), .activeCause(activeCause), .faults(faults),
		.report(report));
	gffm_gate_cards cards (.clk(clk), .rst_n(rst_n), .gateOut(gateOut), .mode(mode),
		.feedback(feedback));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Keep only the first report after power-up
	always @(negedge clk)
		if (report.valid === 1'b1 && firstRep.valid !== 1'b1)
			firstRep = report;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk

	task automatic finishTest;
		$display("checks=%0d mismatches=%0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finishTest

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse

	// Bounded wait for end of pass or for idle
	task automatic waitFor(input bit onDone);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((onDone ? diagDone !== 1'b1 : busy !== 1'b0) && n < 3000);
		if (n >= 3000) begin
			failCount++;
			finishTest();
		end
	endtask : waitFor

	function automatic logic [NUM_DEV-1:0] expMask(input logic [1:0] m);
		for (int i = 0; i < NUM_DEV; i++)
			expMask[i] = (mode[i] == m);
	endfunction : expMask

	task automatic randModes;
		for (int i = 0; i < NUM_DEV; i++)
			mode[i] = 2'($urandom_range(2));
	endtask : randModes

	initial begin
		void'($urandom(99255));
		{rst_n, running, gateCmd, diagReq, driveReset} = '0;
		gateMask = '0;
		diagCause = CAUSE_CONTACTOR;
		delay = 8'h03;
		firstRep = '0;
		randModes();
		mode[0] = 2'h1;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		waitFor(1);
		fb = expMask(2'h1);
		gt = expMask(2'h2);
		chk(faults.fbk, fb);
		chk(faults.gat, gt);
		repeat (8) @(negedge clk);
		chk(firstRep, {1'b1, KIND_FBK, 5'h00, 9'h10B});
		$display("power-up pass done");
		mode = '0;
		pulse(driveReset);
		chk(faults, '0);
		chk(activeCause, CAUSE_RESET);
		waitFor(1);
		chk(faults, '0);
		$display("reset pass done");
		fb = '0;
		gt = '0;
		for (int c = 0; c < 3; c++) begin
			randModes();
			diagCause = causes[c];
			pulse(diagReq);
			waitFor(1);
			fb |= expMask(2'h1);
			gt |= expMask(2'h2);
			chk(activeCause, causes[c]);
			chk(faults.fbk, fb);
			chk(faults.gat, gt);
		end
		$display("requested passes done");
		mode = '0;
		pulse(driveReset);
		waitFor(1);
		pulse(gateCmd);
		chk(busy, 1'b0);
		running = 1'b1;
		// Position 7 has one good firing, so its count restarts and trips only on the sixth
		for (int f = 1; f <= 6; f++) begin
			mode[5] = 2'h2;
			mode[7] = (f == 3) ? 2'h0 : 2'h1;
			mode[9] = 2'h3;
			mode[11] = (f == 6) ? 2'h1 : 2'h0;
			delay = (f == 6) ? 8'h01 : 8'h03;
			gateMask = NUM_DEV'($urandom) | 18'h00AA0;
			pulse(gateCmd);
			waitFor(0);
			chk(faults.onl, f == 6 ? 18'h008A0 : f >= 3 ? 18'h00020 : 18'h0);
			chk(faults.fbk | faults.gat, '0);
		end
		$display("online firings done");
		finishTest();
	end
endmodule : gffm_monitor_tb
`default_nettype wire

/* File: rtl/gffm_code_rom.sv */
// Fault code table with a registered read port
`timescale 1ns/1ns
`default_nettype none

module gffm_code_rom
	import gffm_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Read port
	input  wire logic [ROM_AW-1:0] addr,
	output var  gffm_code_t        data
);

	gffm_code_t r;
	gffm_code_t n;

	assign data = r;

	always_comb begin
		n = '0;
		if (int'(addr) < NUM_DEV) begin
			n = FBK_CODES[int'(addr)];
		end else if (int'(addr) < 2 * NUM_DEV) begin
			n = GAT_CODES[int'(addr) - NUM_DEV];
		end else if (int'(addr) < ROM_DEPTH) begin
			n = ONL_CODES[int'(addr) - 2 * NUM_DEV];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

endmodule : gffm_code_rom

`default_nettype wire

/* File: rtl/gffm_monitor.sv */
// Gate feedback fault monitor: link-loss diagnostics and online feedback check
//
// Operation
// - Sample feedback before and after gate pulse.
// - Low before and after: feedback link loss.
// - High before and after: gating link loss.
// - Link checks at contactor, start, stop.
// - Run diagnostics right after every drive reset.
// - Running: wrong feedback raises online fault once the firing count reaches the delay setting.
// - Running: three polls before, three after firing.
// - Online fault only when six readings agree.
// - Settable delay sets required firing count.
// - Distinct fault code per kind and position.
// - Condition must persist over consecutive firings.
`timescale 1ns/1ns
`default_nettype none

module gffm_monitor
	import gffm_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Device feedback and gating
	input  wire logic [NUM_DEV-1:0] feedback,
	output var  logic [NUM_DEV-1:0] gateOut,
	// Running gating commands
	input  wire logic               running,
	input  wire logic               gateCmd,
	input  wire logic [NUM_DEV-1:0] gateMask,
	// Diagnostic requests and drive reset
	input  wire logic               diagReq,
	input  wire gffm_cause_t        diagCause,
	input  wire logic               driveReset,
	input  wire logic [CNT_W-1:0]   diagnosticDelaySetting,
	// Status
	output var  logic               busy,
	output var  logic               diagDone,
	output var  gffm_cause_t        activeCause,
	// Faults
	output var  gffm_fault_t        faults,
	output var  gffm_report_t       report
);

	typedef struct packed {
		gffm_state_t                   st;
		logic                          online;
		logic                          pend;
		gffm_cause_t                   cause;
		logic [TMR_W-1:0]              tmr;
		logic [POLL_W-1:0]             poll;
		logic [NUM_DEV-1:0]            preAnd;
		logic [NUM_DEV-1:0]            preOr;
		logic [NUM_DEV-1:0]            postAnd;
		logic [NUM_DEV-1:0]            postOr;
		logic [NUM_DEV-1:0]            mask;
		logic [NUM_DEV-1:0]            gate;
		logic [NUM_DEV-1:0][CNT_W-1:0] cnt;
		gffm_fault_t                   faults;
		logic [ROM_DEPTH-1:0]          reported;
		logic [1:0]                    scanStage;
		logic [ROM_AW-1:0]             scanAddr;
		gffm_report_t                  report;
		logic                          busy;
		logic                          done;
	} gffm_regs_t;

	localparam gffm_regs_t REGS_RESET = '{
		st:        ST_IDLE,
		online:    1'b0,
		pend:      1'b1,
		cause:     CAUSE_POWERUP,
		tmr:       '0,
		poll:      '0,
		preAnd:    '0,
		preOr:     '0,
		postAnd:   '0,
		postOr:    '0,
		mask:      '0,
		gate:      '0,
		cnt:       '0,
		faults:    '0,
		reported:  '0,
		scanStage: '0,
		scanAddr:  '0,
		report:    '0,
		busy:      1'b0,
		done:      1'b0
	};

	localparam logic [1:0] SCAN_IDLE = 2'h0;
	localparam logic [1:0] SCAN_ROM  = 2'h1;
	localparam logic [1:0] SCAN_OUT  = 2'h2;

	gffm_regs_t r;
	gffm_regs_t n;
	gffm_code_t romData;

	// Lowest pending table index; ROM_DEPTH when nothing is pending
	function automatic logic [ROM_AW:0] lowestSet(input logic [ROM_DEPTH-1:0] v);
		logic [ROM_AW:0] idx;
		idx = (ROM_AW+1)'(ROM_DEPTH);
		for (int i = ROM_DEPTH - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = (ROM_AW+1)'(i);
			end
		end
		return idx;
	endfunction : lowestSet

	// Split a table index into fault kind and bridge position
	function automatic logic [1:0] addrKind(input logic [ROM_AW-1:0] a);
		if (int'(a) < NUM_DEV) begin
			return KIND_FBK;
		end else if (int'(a) < 2 * NUM_DEV) begin
			return KIND_GAT;
		end
		return KIND_ONL;
	endfunction : addrKind

	function automatic logic [POS_W-1:0] addrPos(input logic [ROM_AW-1:0] a);
		int p;
		p = int'(a);
		if (p >= 2 * NUM_DEV) begin
			p = p - 2 * NUM_DEV;
		end else if (p >= NUM_DEV) begin
			p = p - NUM_DEV;
		end
		return POS_W'(p);
	endfunction : addrPos

	gffm_code_rom u_rom (
		.clk   (clk),
		.rst_n (rst_n),
		.addr  (r.scanAddr),
		.data  (romData)
	);

	assign gateOut     = r.gate;
	assign busy        = r.busy;
	assign diagDone    = r.done;
	assign activeCause = r.cause;
	assign faults      = r.faults;
	assign report      = r.report;

	always_comb begin
		logic [POLL_W-1:0]    polls;
		logic [CNT_W-1:0]     delayEff;
		logic [NUM_DEV-1:0]   agree;
		logic [ROM_AW:0]      pick;
		logic [ROM_DEPTH-1:0] waiting;

		n = r;
		n.done = 1'b0;
		n.report.valid = 1'b0;
		polls = r.online ? POLLS_ONLINE : POLLS_DIAG;
		// A zero setting still needs one bad firing
		delayEff = (diagnosticDelaySetting == '0) ? CNT_W'(1) : diagnosticDelaySetting;
		agree = (r.preAnd ~^ r.preOr) & (r.postAnd ~^ r.postOr) & (r.preAnd ~^ r.postAnd);
		waiting = {r.faults.onl, r.faults.gat, r.faults.fbk} & ~r.reported;
		pick = lowestSet(waiting);

		// Drive reset clears every latch but what ST_EVAL sets in the same cycle, then schedules a diagnostic pass
		if (driveReset) begin
			n.faults = '0;
			n.reported = '0;
			n.cnt = '0;
		end

		unique case (r.st)
			ST_IDLE: begin
				if (r.pend) begin
					n.online = 1'b0;
					n.mask = '1;
					n.pend = 1'b0;
					n.busy = 1'b1;
					n.st = ST_PRE;
					n.tmr = '0;
					n.poll = '0;
					n.preAnd = '1;
					n.preOr = '0;
				end else if (running && gateCmd) begin
					n.online = 1'b1;
					n.mask = gateMask;
					n.busy = 1'b1;
					n.st = ST_PRE;
					n.tmr = '0;
					n.poll = '0;
					n.preAnd = '1;
					n.preOr = '0;
				end
			end
			ST_PRE: begin
				if (r.tmr != '0) begin
					n.tmr = r.tmr - TMR_W'(1);
				end else begin
					n.preAnd = r.preAnd & feedback;
					n.preOr = r.preOr | feedback;
					if (r.poll == polls - POLL_W'(1)) begin
						n.st = ST_FIRE;
						n.gate = r.mask;
						n.tmr = GATE_PULSE_CYC - TMR_W'(1);
					end else begin
						n.poll = r.poll + POLL_W'(1);
						n.tmr = POLL_GAP_CYC - TMR_W'(1);
					end
				end
			end
			ST_FIRE: begin
				if (r.tmr != '0) begin
					n.tmr = r.tmr - TMR_W'(1);
				end else begin
					n.gate = '0;
					n.st = ST_SETTLE;
					n.tmr = SETTLE_CYC - TMR_W'(1);
				end
			end
			ST_SETTLE: begin
				if (r.tmr != '0) begin
					n.tmr = r.tmr - TMR_W'(1);
				end else begin
					n.st = ST_POST;
					n.tmr = '0;
					n.poll = '0;
					n.postAnd = '1;
					n.postOr = '0;
				end
			end
			ST_POST: begin
				if (r.tmr != '0) begin
					n.tmr = r.tmr - TMR_W'(1);
				end else begin
					n.postAnd = r.postAnd & feedback;
					n.postOr = r.postOr | feedback;
					if (r.poll == polls - POLL_W'(1)) begin
						n.st = ST_EVAL;
					end else begin
						n.poll = r.poll + POLL_W'(1);
						n.tmr = POLL_GAP_CYC - TMR_W'(1);
					end
				end
			end
			ST_EVAL: begin
				for (int i = 0; i < NUM_DEV; i++) begin
					if (r.mask[i] && !r.online) begin
						// Diagnostic pass: an unchanged level names the broken link
						if (!r.preOr[i] && !r.postOr[i]) begin
							n.faults.fbk[i] = 1'b1;
						end
						if (r.preAnd[i] && r.postAnd[i]) begin
							n.faults.gat[i] = 1'b1;
						end
					end else if (r.mask[i]) begin
						// Firing where feedback failed to change on all six polls
						if (agree[i]) begin
							if (r.cnt[i] + CNT_W'(1) >= delayEff) begin
								n.faults.onl[i] = 1'b1;
								n.cnt[i] = delayEff;
							end else begin
								n.cnt[i] = r.cnt[i] + CNT_W'(1);
							end
						end else begin
							n.cnt[i] = '0;
						end
					end
				end
				n.st = ST_IDLE;
				n.busy = 1'b0;
				n.done = !r.online;
			end
		endcase

		// A reset aborts any sequence not yet in ST_EVAL and forces a fresh pass
		if (driveReset) begin
			n.st = ST_IDLE;
			n.gate = '0;
			n.busy = 1'b0;
			n.done = 1'b0;
			n.pend = 1'b1;
			n.cause = CAUSE_RESET;
		end else if (diagReq && !r.pend) begin
			n.pend = 1'b1;
			n.cause = diagCause;
		end

		// Report each newly latched fault once, lowest table index first
		unique case (r.scanStage)
			SCAN_IDLE: begin
				if (!driveReset && (int'(pick) < ROM_DEPTH)) begin
					n.scanAddr = pick[ROM_AW-1:0];
					n.reported[int'(pick)] = 1'b1;
					n.scanStage = SCAN_ROM;
				end
			end
			SCAN_ROM: begin
				n.scanStage = SCAN_OUT;
			end
			SCAN_OUT: begin
				n.report.valid = 1'b1;
				n.report.kind = addrKind(r.scanAddr);
				n.report.pos = addrPos(r.scanAddr);
				n.report.code = romData;
				n.scanStage = SCAN_IDLE;
			end
			default: begin
				n.scanStage = SCAN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= REGS_RESET;
		end else begin
			r <= n;
		end
	end

endmodule : gffm_monitor

`default_nettype wire

/* File: rtl/gffm_pkg.sv */
// Shared constants, fault code tables and carrier types for the gate feedback fault monitor
package gffm_pkg;

	// Bridge size and fault code width
	localparam int NUM_DEV   = 18;
	localparam int CODE_W    = 9;
	localparam int NUM_KIND  = 3;
	localparam int ROM_DEPTH = NUM_DEV * NUM_KIND;
	localparam int ROM_AW    = 6;
	localparam int POS_W     = 5;
	localparam int CNT_W     = 8;
	localparam int TMR_W     = 12;
	localparam int POLL_W    = 2;

	// Polls taken on each side of a firing
	localparam logic [POLL_W-1:0] POLLS_ONLINE = 2'h3;
	localparam logic [POLL_W-1:0] POLLS_DIAG   = 2'h1;

	// Fault kinds; each owns one block of NUM_DEV entries in the code table
	localparam logic [1:0] KIND_FBK = 2'h0;
	localparam logic [1:0] KIND_GAT = 2'h1;
	localparam logic [1:0] KIND_ONL = 2'h2;

	// Timing in nanoseconds at the controller clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int GATE_PULSE_NS = 2000;
	localparam int SETTLE_NS     = 4000;
	localparam int POLL_GAP_NS   = 400;

	// Least time rounded up to whole cycles, never below one
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cycles

	localparam logic [TMR_W-1:0] GATE_PULSE_CYC = TMR_W'(ns_to_cycles(GATE_PULSE_NS));
	localparam logic [TMR_W-1:0] SETTLE_CYC     = TMR_W'(ns_to_cycles(SETTLE_NS));
	localparam logic [TMR_W-1:0] POLL_GAP_CYC   = TMR_W'(ns_to_cycles(POLL_GAP_NS));

	typedef logic [CODE_W-1:0] gffm_code_t;

	// Position order: U1 A/B/C, U4 A/B/C, V3 A/B/C, V6 A/B/C, W2 A/B/C, W5 A/B/C
	localparam gffm_code_t FBK_CODES [NUM_DEV] = '{
		9'h10B, 9'h111, 9'h144, 9'h10E, 9'h114, 9'h147,
		9'h10D, 9'h113, 9'h146, 9'h110, 9'h116, 9'h149,
		9'h10C, 9'h112, 9'h145, 9'h10F, 9'h115, 9'h148};
	localparam gffm_code_t GAT_CODES [NUM_DEV] = '{
		9'h117, 9'h11D, 9'h14A, 9'h11A, 9'h120, 9'h14D,
		9'h119, 9'h11F, 9'h14C, 9'h11C, 9'h122, 9'h14F,
		9'h118, 9'h11E, 9'h14B, 9'h11B, 9'h121, 9'h14E};
	localparam gffm_code_t ONL_CODES [NUM_DEV] = '{
		9'h0FF, 9'h105, 9'h13E, 9'h102, 9'h108, 9'h141,
		9'h101, 9'h107, 9'h140, 9'h104, 9'h10A, 9'h143,
		9'h100, 9'h106, 9'h13F, 9'h103, 9'h109, 9'h142};

	// Why a diagnostic sequence is running
	typedef enum logic [2:0] {
		CAUSE_POWERUP,
		CAUSE_RESET,
		CAUSE_CONTACTOR,
		CAUSE_START,
		CAUSE_STOP
	} gffm_cause_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE,
		ST_FIRE,
		ST_SETTLE,
		ST_POST,
		ST_EVAL
	} gffm_state_t;

	// Latched per-position fault flags
	typedef struct packed {
		logic [NUM_DEV-1:0] onl;
		logic [NUM_DEV-1:0] gat;
		logic [NUM_DEV-1:0] fbk;
	} gffm_fault_t;

	// One fault code report
	typedef struct packed {
		logic             valid;
		logic [1:0]       kind;
		logic [POS_W-1:0] pos;
		gffm_code_t       code;
	} gffm_report_t;

endpackage : gffm_pkg
